// File: rtl/host_port_pkg.sv
// constants and types of the dual-channel parallel host port controller
// Notes on behaviour
// - three address lines pick the register
// - one eight-bit two-way data bus
// - host samples read byte at strobe rise
// - write data held until write strobe rises
// - chip select low frames every access
package host_port_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam int CLK_PERIOD_NS = 25;
    // bus phase times in ns
    localparam int ADDR_SETUP_NS = 10;
    localparam int STROBE_LOW_NS = 60;
    localparam int DATA_HOLD_NS = 10;
    localparam int RECOVERY_NS = 40;
    // least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] ADDR_SETUP_CYC =
        CNT_W'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STROBE_LOW_CYC =
        CNT_W'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DATA_HOLD_CYC =
        CNT_W'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RECOVERY_CYC =
        CNT_W'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    // channel pick levels
    localparam logic PICK_CHAN_A = 1'b1;
    localparam logic PICK_CHAN_B = 1'b0;
    // alternate function register: broadcast write bit
    localparam logic [ADDR_W-1:0] ALT_FUNC_ADDR = 3'h2;
    localparam int ALT_FUNC_BCAST_BIT = 0;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SETUP = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD = 5'h08,
        ST_RECOVER = 5'h10
    } bus_state_type;
endpackage : host_port_pkg

// File: rtl/phase_timer_if.sv
// carrier between bus sequencer and phase timer
`timescale 1ns/1ps
interface phase_timer_if;
    import host_port_pkg::*;
    logic load;
    logic [CNT_W-1:0] length;
    logic expired;
    modport ctrl (output load, output length, input expired);
    modport timer (input load, input length, output expired);
endinterface : phase_timer_if

// File: rtl/phase_timer.sv
// down counter that times each bus phase
`timescale 1ns/1ps
module phase_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // sequencer side
    phase_timer_if.timer tmr
);
    import host_port_pkg::*;
    logic [CNT_W-1:0] cnt_q;

    // length loaded as cycles minus one, expires at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= CNT_ZERO;
        end else if (ce) begin
            if (tmr.load) begin
                cnt_q <= tmr.length - CNT_ONE;
            end else if (cnt_q != CNT_ZERO) begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end

    assign tmr.expired = (cnt_q == CNT_ZERO);
endmodule : phase_timer

// File: rtl/uart_host_port.sv
// host-side controller driving the dual-channel port pins
`timescale 1ns/1ps
module uart_host_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // user command side
    input wire logic req,
    input wire logic req_write,
    input wire logic req_chan_b,
    input wire logic [host_port_pkg::ADDR_W-1:0] req_addr,
    input wire logic [host_port_pkg::DATA_W-1:0] req_wdata,
    output logic ready,
    output logic done,
    output logic [host_port_pkg::DATA_W-1:0] rdata,
    // interrupt levels passed to the user
    output logic irq_a,
    output logic irq_b,
    // device pins
    output logic cs_n,
    output logic channel_pick,
    output logic [host_port_pkg::ADDR_W-1:0] addr,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [host_port_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [host_port_pkg::DATA_W-1:0] data_in,
    input wire logic irq_chan_a,
    input wire logic irq_chan_b
);
    import host_port_pkg::*;

    bus_state_type state_q;
    bus_state_type state_d;
    logic write_q;
    logic cs_n_q;
    logic pick_q;
    logic rd_n_q;
    logic wr_n_q;
    logic oe_q;
    logic done_q;
    logic irq_a_q;
    logic irq_b_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] rdata_q;
    logic start;

    phase_timer_if tif ();

    phase_timer u_timer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tmr(tif.timer)
    );

    assign start = req && (state_q == ST_IDLE);

    // phase sequencing
    always_comb begin
        state_d = state_q;
        tif.load = 1'b0;
        tif.length = ADDR_SETUP_CYC;
        unique case (state_q)
            ST_IDLE: begin
                if (req) begin
                    state_d = ST_SETUP;
                    tif.load = 1'b1;
                    tif.length = ADDR_SETUP_CYC;
                end
            end
            ST_SETUP: begin
                if (tif.expired) begin
                    state_d = ST_STROBE;
                    tif.load = 1'b1;
                    tif.length = STROBE_LOW_CYC;
                end
            end
            ST_STROBE: begin
                if (tif.expired) begin
                    state_d = ST_HOLD;
                    tif.load = 1'b1;
                    tif.length = DATA_HOLD_CYC;
                end
            end
            ST_HOLD: begin
                if (tif.expired) begin
                    state_d = ST_RECOVER;
                    tif.load = 1'b1;
                    tif.length = RECOVERY_CYC;
                end
            end
            ST_RECOVER: begin
                if (tif.expired) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // request latch: address, channel, direction
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= '0;
            pick_q <= PICK_CHAN_A;
            write_q <= 1'b0;
        end else if (ce && start) begin
            addr_q <= req_addr;
            pick_q <= req_chan_b ? PICK_CHAN_B : PICK_CHAN_A;
            write_q <= req_write;
        end
    end

    // chip select frames the whole access
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_q <= 1'b1;
        end else if (ce) begin
            if (start) begin
                cs_n_q <= 1'b0;
            end else if (state_q == ST_HOLD && tif.expired) begin
                cs_n_q <= 1'b1;
            end
        end
    end

    // strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (ce) begin
            if (state_q == ST_SETUP && tif.expired) begin
                rd_n_q <= write_q;
                wr_n_q <= !write_q;
            end else if (state_q == ST_STROBE && tif.expired) begin
                rd_n_q <= 1'b1;
                wr_n_q <= 1'b1;
            end
        end
    end

    // write data drive, held past the write strobe rise
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_q <= 1'b0;
            dout_q <= BYTE_ZERO;
        end else if (ce) begin
            if (start) begin
                oe_q <= req_write;
                dout_q <= req_wdata;
            end else if (state_q == ST_HOLD && tif.expired) begin
                oe_q <= 1'b0;
            end
        end
    end

    // read byte sampled as the read strobe rises
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= BYTE_ZERO;
        end else if (ce && state_q == ST_STROBE && tif.expired && !write_q) begin
            rdata_q <= data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= (state_q == ST_RECOVER) && tif.expired;
        end
    end

    // interrupt levels, registered once
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else if (ce) begin
            irq_a_q <= irq_chan_a;
            irq_b_q <= irq_chan_b;
        end
    end

    assign ready = (state_q == ST_IDLE);
    assign done = done_q;
    assign rdata = rdata_q;
    assign irq_a = irq_a_q;
    assign irq_b = irq_b_q;
    assign cs_n = cs_n_q;
    assign channel_pick = pick_q;
    assign addr = addr_q;
    assign read_strobe_n = rd_n_q;
    assign write_strobe_n = wr_n_q;
    assign data_out = dout_q;
    assign data_oe = oe_q;

    // checks
    sequence strobe_low_s;
        (!read_strobe_n || !write_strobe_n);
    endsequence

    sequence strobe_width_s;
        (!read_strobe_n || !write_strobe_n) [*3];
    endsequence

    strobe_excl_a: assert property (@(posedge clk) disable iff (rst)
        !(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");

    cs_frames_a: assert property (@(posedge clk) disable iff (rst)
        strobe_low_s |-> !cs_n)
        else $error("strobe low without chip select");

    strobe_width_a: assert property (@(posedge clk) disable iff (rst)
        ($fell(read_strobe_n) || $fell(write_strobe_n)) |-> strobe_width_s)
        else $error("strobe low too short");

    addr_stable_a: assert property (@(posedge clk) disable iff (rst)
        (!cs_n && $past(!cs_n)) |-> ($stable(addr) && $stable(channel_pick)))
        else $error("address moved inside access");

    write_hold_a: assert property (@(posedge clk) disable iff (rst)
        $rose(write_strobe_n) |-> (data_oe && $past(data_oe) && $stable(data_out)))
        else $error("write data not held over strobe rise");

    read_float_a: assert property (@(posedge clk) disable iff (rst)
        (!read_strobe_n || cs_n) |-> !data_oe)
        else $error("host drives bus during read or idle");

    read_capture_a: assert property (@(posedge clk) disable iff (rst)
        $rose(read_strobe_n) |-> (rdata == $past(data_in)))
        else $error("read byte not sampled at strobe rise");

    done_after_a: assert property (@(posedge clk) disable iff (rst || !ce)
        $rose(cs_n) |-> ##[1:4] done)
        else $error("no done after access");
endmodule : uart_host_port

// File: dv/host_port_device_model.sv
// behavioural dual-channel register file behind the host port pins
`timescale 1ns/1ps
module host_port_device_model (
    // host pins
    input wire logic cs_n,
    input wire logic channel_pick,
    input wire logic [host_port_pkg::ADDR_W-1:0] addr,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [host_port_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    // bus level and interrupts
    output logic [host_port_pkg::DATA_W-1:0] bus_level,
    input wire logic service_a,
    input wire logic service_b,
    output logic irq_chan_a,
    output logic irq_chan_b
);
    import host_port_pkg::*;
    logic [DATA_W-1:0] regs_q [2][8];
    logic [DATA_W-1:0] rd_byte_q;
    logic bcast;
    initial begin
        rd_byte_q = 8'h00;
        for (int r = 0; r < 8; r++) begin
            regs_q[0][r] = 8'h00;
            regs_q[1][r] = 8'h00;
        end
    end
    assign irq_chan_a = service_a;
    assign irq_chan_b = service_b;
    assign bcast = regs_q[0][ALT_FUNC_ADDR][ALT_FUNC_BCAST_BIT];
    always @(negedge read_strobe_n) begin
        if (!cs_n) begin
            rd_byte_q = regs_q[channel_pick == PICK_CHAN_B][addr];
        end
    end
    always @(posedge write_strobe_n) begin
        if (!cs_n && bcast) begin
            regs_q[0][addr] = data_out;
            regs_q[1][addr] = data_out;
        end else if (!cs_n) begin
            regs_q[channel_pick == PICK_CHAN_B][addr] = data_out;
        end
    end
    // released bus shows the inverse of the last byte
    always_comb begin
        if (data_oe) begin
            bus_level = data_out;
        end else if (!cs_n && !read_strobe_n) begin
            bus_level = rd_byte_q;
        end else begin
            bus_level = ~rd_byte_q;
        end
    end
endmodule : host_port_device_model

// File: dv/dual_uart_host_bus_port_bench.sv
// self-checking bench of the host port controller
`timescale 1ns/1ps
module dual_uart_host_bus_port_bench;
    import host_port_pkg::*;
    logic clk, rst, ce, req, req_write, req_chan_b, ready, done, irq_a, irq_b;
    logic [ADDR_W-1:0] req_addr, addr;
    logic [DATA_W-1:0] req_wdata, rdata, data_out, data_in;
    logic cs_n, channel_pick, read_strobe_n, write_strobe_n, data_oe;
    logic irq_chan_a, irq_chan_b, service_a, service_b;
    int fails = 0;
    int checked = 0;
    uart_host_port dut_u (.clk, .rst, .ce, .req, .req_write, .req_chan_b, .req_addr,
        .req_wdata, .ready, .done, .rdata, .irq_a, .irq_b, .cs_n, .channel_pick, .addr,
        .read_strobe_n, .write_strobe_n, .data_out, .data_oe, .data_in, .irq_chan_a,
        .irq_chan_b);
    host_port_device_model dev_u (.cs_n, .channel_pick, .addr, .read_strobe_n,
        .write_strobe_n, .data_out, .data_oe, .bus_level(data_in), .service_a, .service_b,
        .irq_chan_a, .irq_chan_b);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic access(input logic wr, input logic chb, input logic [2:0] a,
        input logic [7:0] wd, input logic [7:0] exp);
        int n;
        int lo;
        int oe;
        int rdy;
        n = 0;
        lo = 0;
        oe = 0;
        rdy = 0;
        req = 1'b1;
        req_write = wr;
        req_chan_b = chb;
        req_addr = a;
        req_wdata = wd;
        @(posedge clk) #1;
        req = 1'b0;
        while (done !== 1'b1 && n < 20) begin
            n++;
            lo += ((wr ? write_strobe_n : read_strobe_n) === 1'b0);
            oe += (data_oe === 1'b1);
            rdy += (ready === 1'b0);
            @(posedge clk) #1;
        end
        check(8'(n + 1), 8'h08);
        check(8'(lo), 8'h03);
        check(8'(oe), wr ? 8'h05 : 8'h00);
        check(8'(rdy), 8'h07);
        if (!wr) check(rdata, exp);
    endtask : access
    task automatic run_map;
        for (int i = 0; i < 8; i++) begin
            access(1'b1, 1'b0, 3'(i), 8'h10 + 8'(i), 8'h00);
            access(1'b1, 1'b1, 3'(i), 8'h80 + 8'(i), 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            access(1'b0, 1'b0, 3'(i), 8'h00, 8'h10 + 8'(i));
            access(1'b0, 1'b1, 3'(i), 8'h00, 8'h80 + 8'(i));
        end
    endtask : run_map
    task automatic run_bcast;
        access(1'b1, 1'b0, ALT_FUNC_ADDR, 8'h01, 8'h00);
        access(1'b1, 1'b1, 3'h5, 8'h5A, 8'h00);
        access(1'b0, 1'b0, 3'h5, 8'h00, 8'h5A);
        access(1'b1, 1'b0, ALT_FUNC_ADDR, 8'h00, 8'h00);
        access(1'b1, 1'b0, 3'h5, 8'hA5, 8'h00);
        access(1'b0, 1'b1, 3'h5, 8'h00, 8'h5A);
    endtask : run_bcast
    task automatic run_irq;
        service_a = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({6'h00, irq_a, irq_b}, 8'h02);
        service_a = 1'b0;
        service_b = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({6'h00, irq_a, irq_b}, 8'h01);
    endtask : run_irq
    task automatic run_reset;
        req = 1'b1;
        req_write = 1'b0;
        req_chan_b = 1'b1;
        req_addr = 3'h3;
        @(posedge clk) #1;
        req = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check({3'h0, ready, cs_n, read_strobe_n, data_oe, done}, 8'h1C);
        check(rdata, 8'h00);
    endtask : run_reset
    task automatic run_freeze;
        ce = 1'b0;
        req = 1'b1;
        req_write = 1'b0;
        req_chan_b = 1'b1;
        req_addr = 3'h3;
        repeat (3) @(posedge clk);
        #1;
        check({6'h00, cs_n, ready}, 8'h03);
        ce = 1'b1;
        req = 1'b0;
        @(posedge clk) #1;
        access(1'b0, 1'b1, 3'h3, 8'h00, 8'h83);
    endtask : run_freeze
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(4000 * CLK_PERIOD_NS);
        fails++;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req = 1'b0;
        req_write = 1'b0;
        req_chan_b = 1'b0;
        req_addr = 3'h0;
        req_wdata = 8'h00;
        service_a = 1'b0;
        service_b = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        check({7'h00, cs_n}, 8'h01);
        check({7'h00, data_oe}, 8'h00);
        run_map;
        run_bcast;
        run_reset;
        run_irq;
        run_freeze;
        print_verdict;
    end
endmodule : dual_uart_host_bus_port_bench
